// >>> logic/emb_ram.sv
// Embedded 4,608-bit block memory: two ports, input stages, output registers, preload
//
// Operation
// - Inputs always registered; output register bypassable
// - Modes: true/simple dual, single, ROM, FIFO
// - Exactly 4,608 bits, parity bits included
// - Nine shapes; 128-deep barred in true dual
// - One unchecked parity bit per byte
// - Byte enables mask writes at every width
// - Masked-off bytes keep previous contents
// - Two half-size single-port memories may share
// - Address clock enable holds captured address
// - RAM or ROM preloadable before operation
// - Same-port read during write returns new
// - Mixed-port read during write returns old
`timescale 1ns/1ps
module emb_ram
    import emb_pkg::*;
(
    input  wire logic                  clk_sys,      // System clock, 250 MHz
    input  wire logic                  reset,        // Synchronous clear, active high
    input  wire logic                  run,          // Low: preload phase, high: ports live
    input  wire emb_mode_e             cfg_mode,     // Memory organisation
    input  wire logic [3:0]            cfg_width_a,  // Port A width code
    input  wire logic [3:0]            cfg_width_b,  // Port B width code
    input  wire logic                  cfg_outreg_a, // Port A output register used
    input  wire logic                  cfg_outreg_b, // Port B output register used
    input  wire logic [EMB_ADDR_W-1:0] a_addr,       // Port A address
    input  wire logic [EMB_ROW_W-1:0]  a_din,        // Port A write data
    input  wire logic [EMB_LANES-1:0]  a_be,         // Port A byte enables
    input  wire logic                  a_we,         // Port A write request
    input  wire logic                  a_re,         // Port A read request
    input  wire logic                  a_addr_hold,  // Port A address clock enable
    input  wire logic [EMB_ADDR_W-1:0] b_addr,       // Port B address
    input  wire logic [EMB_ROW_W-1:0]  b_din,        // Port B write data
    input  wire logic [EMB_LANES-1:0]  b_be,         // Port B byte enables
    input  wire logic                  b_we,         // Port B write request
    input  wire logic                  b_re,         // Port B read request
    input  wire logic                  b_addr_hold,  // Port B address clock enable
    input  wire logic                  load_en,      // Preload one row
    input  wire logic [EMB_ROW_AW-1:0] load_row,     // Preload row address
    input  wire logic [EMB_ROW_W-1:0]  load_word,    // Preload row contents
    output logic      [EMB_ROW_W-1:0]  a_dout,       // Port A read data
    output logic      [EMB_ROW_W-1:0]  b_dout,       // Port B read data
    output logic                       shape_err     // Shape not allowed in this mode
);

    // Storage; power-up contents undefined unless preloaded
    logic [EMB_ROW_W-1:0]  mem [EMB_ROWS];           // The array itself

    // Input stage outputs, index 0 is port A
    logic [EMB_ADDR_W-1:0] addr_q  [2];              // Captured addresses
    logic [EMB_ROW_W-1:0]  din_q   [2];              // Captured data
    logic [EMB_LANES-1:0]  be_q    [2];              // Captured byte enables
    logic                  we_q    [2];              // Captured write requests
    logic                  re_q    [2];              // Captured read requests

    // Access path
    logic [3:0]            wc      [2];              // Width code per port
    logic [11:0]           loc     [2];              // Row and start position
    logic [EMB_ROW_AW-1:0] row     [2];              // Row touched per port
    logic [EMB_ROW_W-1:0]  old     [2];              // Row before this edge
    logic [EMB_ROW_W-1:0]  wmask   [2];              // Physical bits written
    logic [EMB_ROW_W-1:0]  wdat    [2];              // Physical write data
    logic [EMB_ROW_W-1:0]  vmask   [2];              // Port bits in use
    logic [EMB_ROW_W-1:0]  own_new [2];              // Row after own write only
    logic [EMB_ROW_W-1:0]  ext     [2];              // Read word in port layout
    logic [EMB_ROW_W-1:0]  oldx    [2];              // Row before any write, port layout
    logic [5:0]            pidx    [2][EMB_ROW_W];   // Physical bit per port bit
    logic [EMB_ROW_W-1:0]  new_b;                    // Port B row including A's write
    logic                  we_ok   [2];              // Mode lets this port write
    logic                  re_ok   [2];              // Mode lets this port read
    logic                  acc_we  [2];              // Write really happens
    logic                  acc_re  [2];              // Read really happens
    logic                  pack_m;                   // Packed organisation
    logic                  err_d;                    // Shape violation now

    // Output state
    logic [EMB_ROW_W-1:0]  rdata_d [2];              // Next read data
    logic [EMB_ROW_W-1:0]  rdata_q [2];              // Read data, bypass output
    logic [EMB_ROW_W-1:0]  oreg_q  [2];              // Optional output register
    logic                  live_q;                   // Blocks stale requests after clear
    logic                  shape_err_q;              // Registered shape flag

    // Bits per word for a width code
    function automatic logic [5:0] wbits(input logic [3:0] c);
        case (c)
            EMB_WC_1:  return 6'h01;
            EMB_WC_2:  return 6'h02;
            EMB_WC_4:  return 6'h04;
            EMB_WC_8:  return 6'h08;
            EMB_WC_9:  return 6'h09;
            EMB_WC_16: return 6'h10;
            EMB_WC_18: return 6'h12;
            EMB_WC_32: return 6'h20;
            EMB_WC_36: return 6'h24;
            default:   return 6'h00;             // Unknown code moves no bits
        endcase
    endfunction

    // Parity-bearing shapes address whole 9-bit lanes
    function automatic logic is_par(input logic [3:0] c);
        return (c == EMB_WC_9) || (c == EMB_WC_18) || (c == EMB_WC_36);
    endfunction

    // Shift turning a word address into a bit or lane position
    function automatic logic [2:0] wshift(input logic [3:0] c);
        case (c)
            EMB_WC_2,  EMB_WC_18: return 3'h1;
            EMB_WC_4,  EMB_WC_36: return 3'h2;
            EMB_WC_8:             return 3'h3;
            EMB_WC_16:            return 3'h4;
            EMB_WC_32:            return 3'h5;
            default:              return 3'h0;
        endcase
    endfunction

    // Row and start position of a word; packed mode pins each port to its half
    function automatic logic [11:0] locate(input logic [3:0] c, input logic [11:0] addr,
                                           input logic half, input logic pk);
        logic [11:0] pos;
        logic [6:0]  r;
        logic [4:0]  st;
        pos = addr << wshift(c);
        if (is_par(c)) begin
            r  = pos[8:2];                       // Upper address bits beyond depth drop
            st = {3'h0, pos[1:0]};
        end else begin
            r  = pos[11:5];
            st = pos[4:0];
        end
        r[EMB_ROW_AW-1] = pk ? half : r[EMB_ROW_AW-1];
        return {r, st};
    endfunction

    // Physical bit for port bit i; data-only shapes skip every ninth bit
    function automatic logic [5:0] phys(input logic [3:0] c, input logic [4:0] st, input int i);
        logic [4:0] d;
        logic [1:0] ln;
        if (is_par(c)) begin
            ln = 2'(int'(st[1:0]) + i / EMB_LANE_W);
            return 6'(int'(ln) * EMB_LANE_W + i % EMB_LANE_W);
        end
        d = 5'(int'(st) + i);
        return 6'(int'(d[4:3]) * EMB_LANE_W + int'(d[2:0]));
    endfunction

    // Byte enable lane that governs port bit i
    function automatic logic [1:0] lane_of(input logic [3:0] c, input int i);
        return is_par(c) ? 2'(i / EMB_LANE_W) : 2'(i / EMB_BYTE_W);
    endfunction

    // Port A input stage
    emb_inreg u_in_a (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .addr_in   (a_addr),
        .din_in    (a_din),
        .be_in     (a_be),
        .we_in     (a_we),
        .re_in     (a_re),
        .addr_hold (a_addr_hold),
        .addr_q    (addr_q[0]),
        .din_q     (din_q[0]),
        .be_q      (be_q[0]),
        .we_q      (we_q[0]),
        .re_q      (re_q[0])
    );

    // Port B input stage
    emb_inreg u_in_b (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .addr_in   (b_addr),
        .din_in    (b_din),
        .be_in     (b_be),
        .we_in     (b_we),
        .re_in     (b_re),
        .addr_hold (b_addr_hold),
        .addr_q    (addr_q[1]),
        .din_q     (din_q[1]),
        .be_q      (be_q[1]),
        .we_q      (we_q[1]),
        .re_q      (re_q[1])
    );

    // Mode permissions and shape check
    always_comb begin
        wc[0]  = cfg_width_a;
        wc[1]  = cfg_width_b;
        pack_m = (cfg_mode == EMB_MODE_PACK);
        we_ok[0] = 1'b0;
        we_ok[1] = 1'b0;
        re_ok[0] = 1'b0;
        re_ok[1] = 1'b0;
        case (cfg_mode)
            EMB_MODE_TDP, EMB_MODE_PACK: begin
                we_ok[0] = 1'b1;
                we_ok[1] = 1'b1;
                re_ok[0] = 1'b1;
                re_ok[1] = 1'b1;
            end
            EMB_MODE_SDP, EMB_MODE_FIFO: begin   // A writes, B reads
                we_ok[0] = 1'b1;
                re_ok[1] = 1'b1;
            end
            EMB_MODE_SP: begin
                we_ok[0] = 1'b1;
                re_ok[0] = 1'b1;
            end
            EMB_MODE_ROM: re_ok[0] = 1'b1;      // Contents come only from preload
            default: we_ok[0] = 1'b0;           // Illegal mode leaves both ports idle
        endcase
        // 128-deep shapes need both lanes pairs per port, impossible with two full ports
        err_d = (cfg_mode == EMB_MODE_TDP) &&
                (cfg_width_a >= EMB_WC_32 || cfg_width_b >= EMB_WC_32);
        for (int p = 0; p < 2; p++) begin
            acc_we[p] = live_q && run && we_q[p] && we_ok[p] && !err_d;
            acc_re[p] = live_q && run && re_q[p] && re_ok[p] && !err_d;
        end
    end

    // Address mapping, byte masking and read-during-write selection
    always_comb begin
        for (int p = 0; p < 2; p++) begin
            loc[p]   = locate(wc[p], addr_q[p], 1'(p), pack_m);
            row[p]   = loc[p][11:EMB_LOC_ROW_LSB];
            old[p]   = mem[row[p]];
            wmask[p] = EMB_WORD_RST;
            wdat[p]  = EMB_WORD_RST;
            vmask[p] = EMB_WORD_RST;
            ext[p]   = EMB_WORD_RST;
            for (int i = 0; i < EMB_ROW_W; i++) begin
                pidx[p][i] = phys(wc[p], loc[p][EMB_LOC_POS_MSB:0], i);
                if (i < int'(wbits(wc[p]))) begin
                    vmask[p][i]             = 1'b1;
                    wmask[p][pidx[p][i]]    = be_q[p][lane_of(wc[p], i)];
                    wdat[p][pidx[p][i]]     = din_q[p][i];
                end
            end
            own_new[p] = (old[p] & ~wmask[p]) | (wdat[p] & wmask[p]);
            for (int i = 0; i < EMB_ROW_W; i++) begin
                oldx[p][i] = vmask[p][i] & old[p][pidx[p][i]]; // Unwritten view, for the checks
                if (vmask[p][i]) begin
                    // Own write shows at once, the other port's write does not
                    ext[p][i] = acc_we[p] ? own_new[p][pidx[p][i]] : old[p][pidx[p][i]];
                end
            end
            rdata_d[p] = acc_re[p] ? ext[p] : rdata_q[p];
        end
        // Same-row writes from both ports merge; B wins overlapping bits
        new_b = (((acc_we[0] && row[0] == row[1]) ? own_new[0] : old[1]) & ~wmask[1]) | (wdat[1] & wmask[1]);
    end

    // Array update; the whole 4,608-bit store lives here
    always_ff @(posedge clk_sys) begin
        if (load_en && !run) begin
            mem[load_row] <= load_word;
        end else begin
            if (acc_we[0]) begin
                mem[row[0]] <= own_new[0];
            end
            if (acc_we[1]) begin
                mem[row[1]] <= new_b;
            end
        end
    end

    // Output registers; the clear reaches only these, never the input stage or array
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rdata_q[0]  <= EMB_WORD_RST;
            rdata_q[1]  <= EMB_WORD_RST;
            oreg_q[0]   <= EMB_WORD_RST;
            oreg_q[1]   <= EMB_WORD_RST;
            live_q      <= 1'b0;
            shape_err_q <= 1'b0;
        end else begin
            rdata_q[0]  <= rdata_d[0];
            rdata_q[1]  <= rdata_d[1];
            oreg_q[0]   <= rdata_q[0];
            oreg_q[1]   <= rdata_q[1];
            live_q      <= 1'b1;
            shape_err_q <= err_d;
        end
    end

    // Bypass picks the first read stage, otherwise one more cycle of pipeline
    assign a_dout    = cfg_outreg_a ? oreg_q[0] : rdata_q[0];
    assign b_dout    = cfg_outreg_b ? oreg_q[1] : rdata_q[1];
    assign shape_err = shape_err_q;

    // Check helpers: port A write observed alone
    logic                  chk_v_q;              // A wrote last edge, B clear of its row
    logic [EMB_ROW_AW-1:0] chk_row_q;            // Row written
    logic [EMB_ROW_W-1:0]  chk_old_q;            // Row before the write
    logic [EMB_ROW_W-1:0]  chk_mask_q;           // Bits written
    logic [EMB_ROW_W-1:0]  chk_dat_q;            // Data written

    always_ff @(posedge clk_sys) begin
        chk_v_q    <= acc_we[0] && !(acc_we[1] && row[0] == row[1]) && !(load_en && !run);
        chk_row_q  <= row[0];
        chk_old_q  <= old[0];
        chk_mask_q <= wmask[0];
        chk_dat_q  <= wdat[0];
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    AST_OUT_CLEAR: assert property (disable iff (1'b0) reset |=> a_dout == EMB_WORD_RST && b_dout == EMB_WORD_RST)
        else $error("read data not cleared by reset");
    AST_OUT_PIPE: assert property (cfg_outreg_a [*2] |-> a_dout == $past(rdata_q[0]))
        else $error("output register stage out of step");
    AST_ROM_NOWRITE: assert property (cfg_mode == EMB_MODE_ROM |-> !acc_we[0] && !acc_we[1])
        else $error("write accepted in read-only mode");
    AST_SHAPE: assert property (cfg_mode == EMB_MODE_TDP && cfg_width_b == EMB_WC_36 |=> shape_err && !acc_we[0])
        else $error("128-deep shape allowed with two full ports");
    AST_BYTE_WRITE: assert property (chk_v_q |-> ((mem[chk_row_q] ^ chk_dat_q) & chk_mask_q) == EMB_WORD_RST)
        else $error("enabled byte not written");
    AST_BYTE_KEEP: assert property (chk_v_q |-> ((mem[chk_row_q] ^ chk_old_q) & ~chk_mask_q) == EMB_WORD_RST)
        else $error("masked byte changed");
    AST_PACK_HALF: assert property (pack_m && (acc_we[0] || acc_we[1]) |-> row[1][EMB_ROW_AW-1] && !row[0][EMB_ROW_AW-1])
        else $error("packed memory left its half");
    AST_PRELOAD: assert property (load_en && !run |=> mem[$past(load_row)] == $past(load_word))
        else $error("preload row not stored");
    AST_SAME_RDW: assert property (acc_we[0] && acc_re[0] && be_q[0] == EMB_BE_ALL
        |=> (rdata_q[0] & $past(vmask[0])) == $past(din_q[0] & vmask[0]))
        else $error("same-port read missed new data");
    AST_MIXED_RDW: assert property (acc_we[0] && acc_re[1] && !acc_we[1] && wc[0] == wc[1]
        && addr_q[0] == addr_q[1] && !pack_m |=> (rdata_q[1] & $past(vmask[1])) == $past(oldx[0]))
        else $error("mixed-port read saw new data");
    COV_BOTH_WRITE: cover property (acc_we[0] && acc_we[1] && row[0] == row[1]);
    COV_PACKED: cover property (pack_m && acc_we[0] ##1 acc_re[1]);
    COV_SAME_RDW: cover property (acc_we[0] && acc_re[0]);
    COV_PRELOAD: cover property (load_en && !run ##1 run ##2 acc_re[0]);

endmodule

// >>> logic/emb_pkg.sv
// Constants, width codes and mode encodings shared by the embedded block memory
package emb_pkg;

    // Array geometry: 128 rows of four 9-bit lanes
    localparam int EMB_BITS    = 4608;               // Total storage, parity included
    localparam int EMB_ROW_W   = 36;                 // Physical row width
    localparam int EMB_ROWS    = EMB_BITS / EMB_ROW_W; // Row count
    localparam int EMB_ROW_AW  = 7;                  // Row address width
    localparam int EMB_LANE_W  = 9;                  // Byte plus its parity bit
    localparam int EMB_BYTE_W  = 8;                  // Data bits per lane
    localparam int EMB_LANES   = 4;                  // Lanes per row, one byte enable each
    localparam int EMB_ADDR_W  = 12;                 // Widest address, 4K x 1 shape

    // Field positions inside the packed locate result
    localparam int EMB_LOC_ROW_LSB = 5;              // Row field starts here
    localparam int EMB_LOC_POS_MSB = 4;              // Start position field top bit

    // Port width codes, one per supported shape
    localparam logic [3:0] EMB_WC_1  = 4'h0;         // 4K x 1
    localparam logic [3:0] EMB_WC_2  = 4'h1;         // 2K x 2
    localparam logic [3:0] EMB_WC_4  = 4'h2;         // 1K x 4
    localparam logic [3:0] EMB_WC_8  = 4'h3;         // 512 x 8
    localparam logic [3:0] EMB_WC_9  = 4'h4;         // 512 x 9
    localparam logic [3:0] EMB_WC_16 = 4'h5;         // 256 x 16
    localparam logic [3:0] EMB_WC_18 = 4'h6;         // 256 x 18
    localparam logic [3:0] EMB_WC_32 = 4'h7;         // 128 x 32
    localparam logic [3:0] EMB_WC_36 = 4'h8;         // 128 x 36

    // Reset and fill values
    localparam logic [35:0] EMB_WORD_RST = 36'h0;    // Read data after clear
    localparam logic [3:0]  EMB_BE_ALL   = 4'hf;     // Every byte enabled

    // Memory organisation, one-hot
    typedef enum logic [5:0] {
        EMB_MODE_TDP  = 6'h01,                       // True dual-port
        EMB_MODE_SDP  = 6'h02,                       // Simple dual-port, A writes, B reads
        EMB_MODE_SP   = 6'h04,                       // Single-port on A
        EMB_MODE_ROM  = 6'h08,                       // Read-only on A
        EMB_MODE_FIFO = 6'h10,                       // FIFO storage, pointers in fabric
        EMB_MODE_PACK = 6'h20                        // Two half-size single-port memories
    } emb_mode_e;

endpackage

// >>> logic/emb_inreg.sv
// Input register stage of one memory port, write and read requests alike, with address hold
`timescale 1ns/1ps
module emb_inreg
    import emb_pkg::*;
(
    input  wire logic                  clk_sys,    // System clock
    input  wire logic                  reset,      // Only disables the checks below
    input  wire logic [EMB_ADDR_W-1:0] addr_in,    // Address from fabric
    input  wire logic [EMB_ROW_W-1:0]  din_in,     // Write data from fabric
    input  wire logic [EMB_LANES-1:0]  be_in,      // Byte enables from fabric
    input  wire logic                  we_in,      // Write request
    input  wire logic                  re_in,      // Read request
    input  wire logic                  addr_hold,  // Address clock enable, high holds
    output logic      [EMB_ADDR_W-1:0] addr_q,     // Captured address
    output logic      [EMB_ROW_W-1:0]  din_q,      // Captured data
    output logic      [EMB_LANES-1:0]  be_q,       // Captured byte enables
    output logic                       we_q,       // Captured write request
    output logic                       re_q        // Captured read request
);

    logic [EMB_ADDR_W-1:0] addr_d;                 // Next address

    // Address follows the pin unless held
    always_comb begin
        if (addr_hold) begin
            addr_d = addr_q;
        end else begin
            addr_d = addr_in;
        end
    end

    // Always-present input stage; no clear reaches it so a reset never disturbs it
    always_ff @(posedge clk_sys) begin
        addr_q <= addr_d;
        din_q  <= din_in;
        be_q   <= be_in;
        we_q   <= we_in;
        re_q   <= re_in;
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    AST_ADDR_HOLD: assert property (addr_hold |=> addr_q == $past(addr_q))
        else $error("held address register changed");
    AST_ADDR_TAKE: assert property (!addr_hold |=> addr_q == $past(addr_in) && we_q == $past(we_in))
        else $error("input stage missed a request");
    COV_HOLD: cover property (addr_hold [*3]);

endmodule

// >>> bench/emb_fabric.sv
// Fabric-side user logic that packs four bytes with their parity bits
`timescale 1ns/1ps
module emb_fabric (
    input  wire logic [31:0] bytes_in, // Four data bytes
    output logic      [35:0] word_out  // Lanes of byte plus parity
);
    // Parity is made out here, the block only stores it
    always_comb begin
        for (int j = 0; j < 4; j++) begin
            word_out[9*j +: 9] = {^bytes_in[8*j +: 8], bytes_in[8*j +: 8]};
        end
    end
endmodule

// >>> bench/emb_ram_tb.sv
// Self-checking bench for the embedded block memory
`timescale 1ns/1ps
module emb_ram_tb
    import emb_pkg::*;
;
    logic        clk_sys, reset, run, cfg_outreg_b, a_we, a_re, b_re, b_addr_hold, load_en, shape_err; // Controls
    emb_mode_e   cfg_mode;                        // Organisation
    logic [3:0]  cfg_width_a, cfg_width_b, a_be;  // Shapes and enables
    logic [11:0] a_addr, b_addr;                  // Addresses
    logic [6:0]  load_row;                        // Preload row
    logic [35:0] a_din, load_word, a_dout, b_dout, exp_v; // Data
    logic [31:0] fab_bytes, seed;                 // Fabric bytes, random state
    logic [35:0] mem [128];                       // Shadow of the array
    int          mismatches, compares, cycles;    // Bookkeeping
    emb_fabric u_emb_fabric (.bytes_in(fab_bytes), .word_out(a_din));
    // Port B write side and A hold unused in the tested modes
    emb_ram u_emb_ram (.clk_sys(clk_sys), .reset(reset), .run(run), .cfg_mode(cfg_mode), .cfg_width_a(cfg_width_a),
        .cfg_width_b(cfg_width_b), .cfg_outreg_a(cfg_outreg_b), .cfg_outreg_b(cfg_outreg_b), .a_addr(a_addr), .a_din(a_din),
        .a_be(a_be), .a_we(a_we), .a_re(a_re), .a_addr_hold(1'b0), .b_addr(b_addr), .b_din(36'h0), .b_be(4'h0),
        .b_we(1'b0), .b_re(b_re), .b_addr_hold(b_addr_hold), .load_en(load_en), .load_row(load_row),
        .load_word(load_word), .a_dout(a_dout), .b_dout(b_dout), .shape_err(shape_err));
    // Galois-free shift register, fixed start keeps runs repeatable
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Lanes with enable high take new data
    function automatic logic [35:0] merge(input logic [35:0] old, input logic [35:0] d, input logic [3:0] be);
        merge = old;
        for (int j = 0; j < 4; j++) if (be[j]) merge[9*j +: 9] = d[9*j +: 9];
    endfunction
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    // One access cycle on both ports; leaves exp_v as the old B word
    task automatic go(input logic aw, ar, br, hold, input logic [11:0] aa, ba, input logic [3:0] be);
        @(posedge clk_sys);
        seed = lfsr(seed);
        fab_bytes <= seed;
        a_we <= aw;
        a_re <= ar;
        b_re <= br;
        b_addr_hold <= hold;
        a_addr <= aa;
        b_addr <= ba;
        a_be <= be;
        @(posedge clk_sys);
        a_we <= 1'b0;
        a_re <= 1'b0;
        b_re <= 1'b0;
        exp_v = mem[ba[6:0]];
        if (aw) mem[aa[6:0]] = merge(mem[aa[6:0]], a_din, be);
        @(posedge clk_sys);
        #1;
    endtask
    task automatic give_verdict();
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // Hang guard, far above the few hundred cycles needed
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            give_verdict();
        end
    end
    initial begin
        {reset, run, cfg_outreg_b, a_we, a_re, b_re, b_addr_hold, load_en} = 8'h80;
        {a_addr, b_addr, a_be, load_row, load_word, fab_bytes} = '0;
        {cfg_width_a, cfg_width_b, seed} = {EMB_WC_36, EMB_WC_36, 32'h0001755c};
        cfg_mode = EMB_MODE_SDP;
        repeat (4) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        chk(a_dout, EMB_WORD_RST);
        chk(b_dout, EMB_WORD_RST);
        // Preload every row while the ports are parked
        for (int i = 0; i < 128; i++) begin
            @(posedge clk_sys);
            seed = lfsr(seed);
            {load_en, load_row, load_word} <= {1'b1, i[6:0], seed[3:0], seed};
            mem[i] = {seed[3:0], seed};
        end
        @(posedge clk_sys);
        load_en <= 1'b0;
        run <= 1'b1;
        // Random writes on A with reads on B; first a collision, then an empty mask
        for (int i = 0; i < 40; i++) begin
            seed = lfsr(seed);
            go(i < 2 || seed[14], 1'b0, 1'b1, 1'b0, seed[11:0], (i == 0) ? seed[11:0] : seed[27:16],
               (i == 1) ? 4'h0 : seed[31:28]);
            chk(b_dout, exp_v);
        end
        go(1'b0, 1'b0, 1'b1, 1'b0, 12'h005, 12'h005, 4'h0);
        go(1'b0, 1'b0, 1'b1, 1'b1, 12'h005, 12'h009, 4'h0);
        chk(b_dout, mem[5]);
        @(posedge clk_sys);
        cfg_outreg_b <= 1'b1;
        go(1'b0, 1'b0, 1'b1, 1'b0, 12'h005, 12'h009, 4'h0);
        chk(b_dout, mem[5]);
        @(posedge clk_sys);
        #1;
        chk(b_dout, mem[9]);
        cfg_outreg_b <= 1'b0;
        cfg_mode <= EMB_MODE_PACK;
        // Same address on both halves: A lands in row 5, B reads row 69
        go(1'b1, 1'b1, 1'b1, 1'b0, 12'h005, 12'h005, 4'hf);
        chk(a_dout, mem[5]);
        chk(b_dout, mem[69]);
        cfg_mode <= EMB_MODE_SP;
        go(1'b1, 1'b1, 1'b0, 1'b0, 12'h014, 12'h000, 4'h5);
        chk(a_dout, mem[20]);
        cfg_mode <= EMB_MODE_ROM;
        // B idles on row 21 so exp_v keeps the word the refused write must not touch
        go(1'b1, 1'b1, 1'b0, 1'b0, 12'h015, 12'h015, 4'hf);
        mem[21] = exp_v;
        chk(a_dout, exp_v);
        cfg_mode <= EMB_MODE_TDP;
        repeat (3) @(posedge clk_sys);
        #1;
        chk({35'h0, shape_err}, 36'h1);
        {cfg_width_a, cfg_width_b} <= {EMB_WC_18, EMB_WC_18};
        repeat (3) @(posedge clk_sys);
        #1;
        chk({35'h0, shape_err}, 36'h0);
        {reset, cfg_width_a, cfg_width_b} <= {1'b1, EMB_WC_36, EMB_WC_36};
        cfg_mode <= EMB_MODE_SDP;
        @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        #1;
        chk(b_dout, EMB_WORD_RST);
        go(1'b0, 1'b0, 1'b1, 1'b0, 12'h000, 12'h014, 4'h0);
        chk(b_dout, mem[20]);
        give_verdict();
    end
endmodule
